// File: hw/dio_ddr_cell.sv
`timescale 1ns/1ps

// Contract
// [RL1] Output mux sends one bit per edge
// [RL2] Clock source gives inverse clocks, near 50%
// [RL3] Second clock may be local inverse
// [RL4] Output enable has same dual-edge pair
// [RL5] Input pair captures alternate bits per clock
// [RL6] Output pair can forward clock to pin
// [RL7] Cascade allowed only in differential mode
// [RL8] Cascade links hidden from core logic
// [RL9] Input bits taken on first, second rises
// [RL10] Core retimes second input bit uncascaded
// [RL11] Input cascade recaptures second bit on first
// [RL12] Output bits loaded on first, second rises
// [RL13] Core retimes second output bit uncascaded
// [RL14] Output cascade stages second bit via partner
// [RL15] Load only on active edge with enable
// [RL16] Set and reverse together give zero
// [RL17] Upper set polarity applies to pair
// [RL18] Reset loads configured initial value
// [RL19] Mux picks upper while first clock high
module dio_ddr_cell
  import dio_pkg::*;
#(
  parameter logic SET_POL = SET_POL_RESET,
  parameter logic INIT_UP = INIT_RESET,
  parameter logic INIT_LO = INIT_RESET
) (
  // Clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  // Register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // Link clocks and pin
  input  wire logic       firstClkPin,
  input  wire logic       secondClkPin,
  input  wire logic       pinIn,
  output logic            pinOut,
  output logic            pinOe,
  // Core data
  input  wire logic       txFirst,
  input  wire logic       txSecond,
  input  wire logic       oeFirst,
  input  wire logic       oeSecond,
  output logic            rxFirst,
  output logic            rxSecond,
  output logic            rxValid,
  // Set and reverse
  input  wire logic       setReset,
  input  wire logic       reverse
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] syncD;
    logic       lvl1;
    logic       lvl2;
    logic       lvlD;
    logic       partnerIn;
    logic       partnerOut;
    logic       rxLo;
    logic       rxVal;
    logic       pinOut;
    logic       pinOe;
    logic [7:0] ctrl;
    logic [7:0] rdData;
  } dio_cell_t;

  dio_cell_t  st;
  dio_cell_t  next_st;
  logic [1:0] rstSync;
  logic       rstnSync;
  logic       new1;
  logic       new2;
  logic       newD;
  logic       firstRise;
  logic       secondRise;
  logic       cascIn;
  logic       cascOut;
  logic       fwd;
  logic       outUp;
  logic       outLo;
  logic       oeUp;
  logic       oeLo;
  logic       inUp;
  logic       inLo;
  logic       outDUp;
  logic       outDLo;
  logic [7:0] status;

  // ****************************************************
  // Reset release
  // ****************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnSync = rstSync[1];

  // ****************************************************
  // Pin filtering and edge events
  // ****************************************************
  // A level counts once the two later sync stages agree
  assign new1 = (st.sync1[1] == st.sync1[2]) ? st.sync1[2] : st.lvl1;
  assign new2 = (st.sync2[1] == st.sync2[2]) ? st.sync2[2] : st.lvl2;
  assign newD = (st.syncD[1] == st.syncD[2]) ? st.syncD[2] : st.lvlD;

  assign firstRise  = new1 && !st.lvl1;
  // Local inversion: the falling first edge clocks the lower half
  assign secondRise = st.ctrl[CTRL_LOC_INV] ?
                      (!new1 && st.lvl1) : // RL3
                      (new2 && !st.lvl2);

  // Cascade paths exist only for a differential pair
  assign cascIn  = st.ctrl[CTRL_DIFF] && st.ctrl[CTRL_CASC_IN];  // RL7
  assign cascOut = st.ctrl[CTRL_DIFF] && st.ctrl[CTRL_CASC_OUT]; // RL7
  assign fwd     = st.ctrl[CTRL_CLK_FWD];

  // ****************************************************
  // Register pairs
  // ****************************************************
  // Forwarding a clock: constant one above, zero below
  assign outDUp = fwd ? 1'b1 : txFirst; // RL6
  assign outDLo = fwd ? 1'b0 :
                  (cascOut ? st.partnerOut : txSecond); // RL14 RL12

  dio_reg_pair #(
    .SET_POL  (SET_POL),
    .INIT_UP  (INIT_UP),
    .INIT_LO  (INIT_LO)
  ) u_out (
    .core_clk (core_clk),
    .rstnSync (rstnSync),
    .clkEn    (clkEn),
    .ce       (st.ctrl[CTRL_CE_OUT]),
    .loadUp   (firstRise),
    .loadLo   (secondRise),
    .dUp      (outDUp),
    .dLo      (outDLo),
    .setReset (setReset),
    .reverse  (reverse),
    .qUp      (outUp),
    .qLo      (outLo)
  ); // RL12

  dio_reg_pair #(
    .SET_POL  (SET_POL),
    .INIT_UP  (INIT_UP),
    .INIT_LO  (INIT_LO)
  ) u_oe (
    .core_clk (core_clk),
    .rstnSync (rstnSync),
    .clkEn    (clkEn),
    .ce       (st.ctrl[CTRL_CE_OE]),
    .loadUp   (firstRise),
    .loadLo   (secondRise),
    .dUp      (oeFirst),
    .dLo      (oeSecond),
    .setReset (setReset),
    .reverse  (reverse),
    .qUp      (oeUp),
    .qLo      (oeLo)
  ); // RL4

  dio_reg_pair #(
    .SET_POL  (SET_POL),
    .INIT_UP  (INIT_UP),
    .INIT_LO  (INIT_LO)
  ) u_in (
    .core_clk (core_clk),
    .rstnSync (rstnSync),
    .clkEn    (clkEn),
    .ce       (st.ctrl[CTRL_CE_IN]),
    .loadUp   (firstRise),
    .loadLo   (secondRise),
    .dUp      (newD),
    .dLo      (newD),
    .setReset (setReset),
    .reverse  (reverse),
    .qUp      (inUp),
    .qLo      (inLo)
  ); // RL5 RL9

  // ****************************************************
  // Status
  // ****************************************************
  always_comb begin
    status                 = 8'h00;
    status[STAT_RX_FIRST]  = inUp;
    status[STAT_RX_SECOND] = st.rxLo;
    status[STAT_PIN_OUT]   = st.pinOut;
    status[STAT_PIN_OE]    = st.pinOe;
    status[STAT_CLK_LEVEL] = st.lvl1;
    status[STAT_CASC_IN]   = cascIn;
    status[STAT_CASC_OUT]  = cascOut;
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_st = st;
    if (clkEn) begin
      next_st.sync1 = {st.sync1[1:0], firstClkPin};
      next_st.sync2 = {st.sync2[1:0], secondClkPin};
      next_st.syncD = {st.syncD[1:0], pinIn};
      next_st.lvl1  = new1;
      next_st.lvl2  = new2;
      next_st.lvlD  = newD;
      // Partner stages are internal only, no port reaches them
      if (firstRise && st.ctrl[CTRL_CE_IN]) begin
        next_st.partnerIn = inLo; // RL11 RL8
      end
      if (firstRise && st.ctrl[CTRL_CE_OUT]) begin
        next_st.partnerOut = txSecond; // RL14 RL8
      end
      // Uncascaded, the core must retime this bit itself
      // Recaptured bit shows beside the upper bit of the next pair
      next_st.rxLo  = cascIn ? next_st.partnerIn : inLo; // RL11 RL10
      next_st.rxVal = firstRise;
      // Pin follows upper while first clock high
      next_st.pinOut = st.lvl1 ? outUp : outLo; // RL19 RL1
      next_st.pinOe  = st.lvl1 ? oeUp : oeLo;   // RL19 RL4
      if (regWr && regAddr == ADDR_CTRL) begin
        next_st.ctrl = regWrData;
      end
      if (regRd) begin
        case (regAddr)
          ADDR_CTRL:   next_st.rdData = st.ctrl;
          ADDR_STATUS: next_st.rdData = status;
          default:     next_st.rdData = 8'h00;
        endcase
      end else begin
        next_st.rdData = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      st       <= '0;
      st.ctrl  <= CTRL_RESET;
      // Start at the idle level, else a false second edge follows
      st.sync2 <= {3{SECOND_CLK_IDLE}};
      st.lvl2  <= SECOND_CLK_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign pinOut    = st.pinOut;
  assign pinOe     = st.pinOe;
  assign rxFirst   = inUp;
  assign rxSecond  = st.rxLo;
  assign rxValid   = st.rxVal;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstnSync);

  out_first_bit_a: assert property ( // RL1
    (firstRise && clkEn && st.ctrl[CTRL_CE_OUT] && !fwd &&
     !setReset && !reverse) ##1 clkEn
    |=> pinOut == $past(txFirst, 2))
    else $error("first output bit not on pin");

  oe_first_bit_a: assert property ( // RL4
    (firstRise && clkEn && st.ctrl[CTRL_CE_OE] &&
     !setReset && !reverse) ##1 clkEn
    |=> pinOe == $past(oeFirst, 2))
    else $error("first enable bit not on pin");

  in_first_cap_a: assert property ( // RL9
    firstRise && clkEn && st.ctrl[CTRL_CE_IN] && !setReset && !reverse
    |=> rxFirst == $past(newD))
    else $error("first input bit not captured");

  in_local_inv_a: assert property ( // RL3
    st.ctrl[CTRL_LOC_INV] && !new1 && st.lvl1 && clkEn &&
    st.ctrl[CTRL_CE_IN] && !setReset && !reverse
    |=> inLo == $past(newD))
    else $error("local inverse edge missed lower capture");

  in_cascade_a: assert property ( // RL11
    firstRise && clkEn && cascIn && st.ctrl[CTRL_CE_IN]
    |=> rxSecond == $past(inLo))
    else $error("cascaded second bit wrong");

  no_casc_diff_a: assert property ( // RL7
    !st.ctrl[CTRL_DIFF] && clkEn |=> rxSecond == $past(inLo))
    else $error("cascade used without differential mode");

  out_cascade_a: assert property ( // RL14
    secondRise && cascOut && !fwd && clkEn && st.ctrl[CTRL_CE_OUT] &&
    !setReset && !reverse |=> outLo == $past(st.partnerOut))
    else $error("lower output missed partner bit");

  clk_fwd_a: assert property ( // RL6
    firstRise && fwd && clkEn && st.ctrl[CTRL_CE_OUT] &&
    !setReset && !reverse |=> outUp)
    else $error("forwarded clock upper half not one");

  pair_polarity_a: assert property ( // RL17
    setReset && !reverse && clkEn |=> outUp == outLo && inUp == inLo)
    else $error("pair halves disagree after set");

endmodule // dio_ddr_cell

// File: hw/dio_reg_pair.sv
`timescale 1ns/1ps

module dio_reg_pair
  import dio_pkg::*;
#(
  parameter logic SET_POL = SET_POL_RESET,
  parameter logic INIT_UP = INIT_RESET,
  parameter logic INIT_LO = INIT_RESET
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstnSync,
  input  wire logic clkEn,
  // Loading
  input  wire logic ce,
  input  wire logic loadUp,
  input  wire logic loadLo,
  input  wire logic dUp,
  input  wire logic dLo,
  // Set and reverse controls
  input  wire logic setReset,
  input  wire logic reverse,
  // Stored bits
  output logic      qUp,
  output logic      qLo
);

  typedef struct packed {
    logic up;
    logic lo;
  } dio_pair_t;

  dio_pair_t st;
  dio_pair_t next_st;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_st = st;
    if (clkEn) begin
      if (setReset && reverse) begin
        next_st.up = 1'b0; // RL16
        next_st.lo = 1'b0; // RL16
      end else if (setReset) begin
        // One polarity for both halves of the pair
        next_st.up = SET_POL; // RL17
        next_st.lo = SET_POL; // RL17
      end else if (reverse) begin
        next_st.up = ~SET_POL;
        next_st.lo = ~SET_POL;
      end else if (ce) begin
        if (loadUp) begin
          next_st.up = dUp; // RL15
        end
        if (loadLo) begin
          next_st.lo = dLo; // RL15
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      st.up <= INIT_UP; // RL18
      st.lo <= INIT_LO; // RL18
    end else begin
      st <= next_st;
    end
  end

  assign qUp = st.up;
  assign qLo = st.lo;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstnSync);

  sr_rev_zero_a: assert property ( // RL16
    setReset && reverse && clkEn |=> !qUp && !qLo)
    else $error("set and reverse together did not clear pair");

  ce_hold_a: assert property ( // RL15
    !ce && !setReset && !reverse |=> $stable(qUp) && $stable(qLo))
    else $error("pair changed with enable low");

endmodule // dio_reg_pair

// File: shared/dio_pkg.sv
package dio_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // ****************************************************
  // Control fields
  // ****************************************************
  localparam int CTRL_DIFF     = 0;
  localparam int CTRL_CASC_IN  = 1;
  localparam int CTRL_CASC_OUT = 2;
  localparam int CTRL_LOC_INV  = 3;
  localparam int CTRL_CLK_FWD  = 4;
  localparam int CTRL_CE_OUT   = 5;
  localparam int CTRL_CE_OE    = 6;
  localparam int CTRL_CE_IN    = 7;
  // Enables read as asserted until software clears them
  localparam logic [7:0] CTRL_RESET = 8'he0;

  // ****************************************************
  // Status fields
  // ****************************************************
  localparam int STAT_RX_FIRST  = 0;
  localparam int STAT_RX_SECOND = 1;
  localparam int STAT_PIN_OUT   = 2;
  localparam int STAT_PIN_OE    = 3;
  localparam int STAT_CLK_LEVEL = 4;
  localparam int STAT_CASC_IN   = 5;
  localparam int STAT_CASC_OUT  = 6;

  // ****************************************************
  // Storage element defaults
  // ****************************************************
  localparam logic SET_POL_RESET = 1'b0;
  localparam logic INIT_RESET    = 1'b0;

  // ****************************************************
  // Link clock idle levels
  // ****************************************************
  // Second clock idles high, being the inverse of the first
  localparam logic SECOND_CLK_IDLE = 1'b1;

endpackage

// File: verification/dio_link_partner.sv
`timescale 1ns/1ps

// ********************
// Far-side DDR link model
// ********************
module dio_link_partner (
  // Mode
  input  wire logic noSecond,
  // Link pins
  output logic      firstClk,
  output logic      secondClk,
  output logic      dataOut
);
  // Inverse clock, held low when the source omits it
  assign secondClk = noSecond ? 1'b0 : ~firstClk;

  initial begin
    firstClk = 1'b0;
    dataOut  = 1'b1;
  end

  // Data moves a quarter period off each edge to clear the sync stages
  task automatic sendPair(input logic a, input logic b);
    #37 dataOut = a;
    #200 firstClk = 1'b1;
    #200 dataOut = b;
    #200 firstClk = 1'b0;
    #200 dataOut = ~b;
  endtask

  // Free clock for transmit; stands low between runs
  task automatic runClk(input int periods);
    #37;
    repeat (periods) begin
      firstClk = 1'b1;
      #400 firstClk = 1'b0;
      dataOut = ~dataOut;
      #400;
    end
  endtask
endmodule // dio_link_partner

// File: verification/test_dio_ddr_cell.sv
`timescale 1ns/1ps

module test_dio_ddr_cell
  import dio_pkg::*;
;
  // ********************
  // Signals
  // ********************
  logic       core_clk, rstn, clkEn, regWr, regRd;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rdVal;
  logic       pinOut, pinOe, rxFirst, rxSecond, rxValid;
  logic       txFirst, txSecond, oeFirst, oeSecond;
  logic       setReset, reverse, firstClk, secondClk, linkData;
  logic       noSecond, lastFirst, lastSecond;
  logic [7:0] modes [3] = '{8'he0, 8'he5, 8'he8};
  int         fails = 0, samples_checked = 0, cycles = 0;
  int         validCount = 0, ones, oeOnes;

  always #50 core_clk = ~core_clk;

  dio_ddr_cell uut (
    .core_clk, .rstn, .clkEn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .firstClkPin(firstClk), .secondClkPin(secondClk),
    .pinIn(linkData), .pinOut, .pinOe, .txFirst, .txSecond, .oeFirst,
    .oeSecond, .rxFirst, .rxSecond, .rxValid, .setReset, .reverse
  );

  dio_link_partner partner (
    .noSecond  (noSecond),
    .firstClk  (firstClk),
    .secondClk (secondClk),
    .dataOut   (linkData)
  );

  // ********************
  // Capture and timeout
  // ********************
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (rxValid === 1'b1) begin
      lastFirst  <= rxFirst;
      lastSecond <= rxSecond;
      validCount <= validCount + 1;
    end
    if (cycles == 5000) begin
      fails = fails + 1;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [7:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
  endtask

  task automatic endTest(input string n);
    $display("Test %s finished", n);
  endtask

  // Each pair leaves one valid pulse; lower bit lags by a pair
  task automatic rxTest(input logic [7:0] ctrl, input logic skip);
    logic prevB;
    int   n;
    wr(ADDR_CTRL, ctrl);
    noSecond = skip;
    for (int i = 0; i < 4; i++) begin
      n = validCount;
      @(posedge core_clk);
      partner.sendPair(i[1], i[0]);
      repeat (2) @(posedge core_clk);
      chk(8'(validCount - n), 8'h01, "valid pulses");
      chk({7'h0, lastFirst}, {7'h0, i[1]}, "first bit");
      if (i > 0)
        chk({7'h0, lastSecond}, {7'h0, prevB}, "second bit");
      prevB = i[0];
    end
    noSecond = 1'b0;
  endtask

  // Counts pin high cycles over one settled link period
  task automatic txCount(input logic [1:0] tx, input logic [1:0] oe);
    @(posedge core_clk);
    txFirst  <= tx[1];
    txSecond <= tx[0];
    oeFirst  <= oe[1];
    oeSecond <= oe[0];
    ones   = 0;
    oeOnes = 0;
    fork
      partner.runClk(4);
      begin
        repeat (16) @(posedge core_clk);
        repeat (8) begin
          @(posedge core_clk);
          #1 ones += (pinOut === 1'b1);
          oeOnes += (pinOe === 1'b1);
        end
      end
    join
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    {core_clk, rstn, regWr, regRd, regAddr, regWrData} = '0;
    {txFirst, txSecond, oeFirst, oeSecond, setReset, reverse} = '0;
    clkEn    = 1'b1;
    noSecond = 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ADDR_CTRL);
    chk(rdVal, CTRL_RESET, "ctrl reset");
    rd(ADDR_STATUS);
    chk(rdVal, 8'h00, "status reset");
    wr(4'hc, 8'h1f);
    rd(4'hc);
    chk(rdVal, 8'h00, "unmapped read");
    rd(ADDR_CTRL);
    chk(rdVal, CTRL_RESET, "ctrl kept");
    wr(ADDR_CTRL, 8'he6);
    rd(ADDR_STATUS);
    chk(rdVal & 8'h60, 8'h00, "cascade single ended");
    wr(ADDR_CTRL, 8'he7);
    rd(ADDR_STATUS);
    chk(rdVal & 8'h60, 8'h60, "cascade differential");
    endTest("registers");
    rxTest(8'he0, 1'b0);
    rxTest(8'he3, 1'b0);
    rxTest(8'he8, 1'b1);
    endTest("receive");
    // Plain, output cascade, local inversion
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, modes[m]);
      noSecond = (m == 2);
      for (int c = 0; c < 4; c++) begin
        txCount(c[1:0], ~c[1:0]);
        chk(8'(ones), 8'(4 * (c[1] + c[0])), "pin data");
        chk(8'(oeOnes), 8'(8 - 4 * (c[1] + c[0])), "pin enable");
      end
    end
    noSecond = 1'b0;
    endTest("transmit");
    wr(ADDR_CTRL, 8'hf0);
    txCount(2'b00, 2'b11);
    chk(8'(ones), 8'h04, "clock forward");
    wr(ADDR_CTRL, 8'he0);
    txCount(2'b11, 2'b11);
    wr(ADDR_CTRL, 8'hc0);
    txCount(2'b00, 2'b00);
    chk(8'(ones), 8'h08, "output frozen");
    chk(8'(oeOnes), 8'h00, "enable still loads");
    wr(ADDR_CTRL, 8'he0);
    txCount(2'b00, 2'b00);
    @(posedge core_clk);
    clkEn <= 1'b0;
    txCount(2'b11, 2'b11);
    chk(8'(ones + oeOnes), 8'h00, "clock enable freeze");
    @(posedge core_clk);
    clkEn <= 1'b1;
    endTest("enables");
    @(posedge core_clk);
    reverse <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk({6'h0, pinOut, rxFirst}, 8'h03, "reverse");
    @(posedge core_clk);
    setReset <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk({6'h0, pinOut, rxFirst}, 8'h00, "set and reverse");
    @(posedge core_clk);
    reverse <= 1'b0;
    txCount(2'b11, 2'b11);
    chk(8'(ones + oeOnes), 8'h00, "reset held");
    @(posedge core_clk);
    setReset <= 1'b0;
    endTest("set reset");
    test_done();
  end
endmodule // test_dio_ddr_cell
